// ---- pkg/mswt_map.svh ----
// Overview of operation
// - A programmable table describes one quarter wave, 0 to 90 degrees, in 256 entries.
// - The quarter wave is mirrored automatically into a full wave of 1024 microsteps.
// - The 10-bit microstep position runs 0 to 1023 and addresses the full wave.
// - The quarter wave is coded as exactly 256 delta-select bits, one per entry.
// - The 256 delta-select bits live in eight 32-bit registers, indices 0x70 to 0x77.
// - Each value after the first is the previous value plus an increment.
// - Increment is segment slope when delta bit is 1, slope minus one when 0.
// - Each base slope is two bits, 0 to 3; slope 0 gives steps of -1 or 0.
// - Four segments bounded by 0, three programmable borders and 255; segment n uses slope n.
// - The first phase wave starts from its own programmable start value.
// - The second phase wave starts from its own separate programmable start value.
// - Every microstep advance computes both coil values into readable register 0x7A.
// - Passing microstep position zero reloads both coil values from their start values.
// - The second coil wave is shifted by exactly a quarter period from the first.
// - All slopes and borders are set through one configuration register at 0x78.
// - Border three 31:24, two 23:16, one 15:8; slopes three..zero in 7:6..1:0.
// - Phase A start value in bits 7:0, phase B start in 23:16 of 0x7E.
// - Phase A starts at position 0, phase B at fixed position 256.
`ifndef MSWT_MAP_SVH
`define MSWT_MAP_SVH

// register indices; byte address is four times the index
`define MSWT_IDX_TABLE_FIRST 8'h70
`define MSWT_IDX_TABLE_LAST 8'h77
`define MSWT_IDX_SEG_CFG 8'h78
`define MSWT_IDX_POSITION 8'h79
`define MSWT_IDX_COIL 8'h7a
`define MSWT_IDX_START 8'h7e

// segment configuration fields
`define MSWT_BORDER_THREE_MSB 31
`define MSWT_BORDER_THREE_LSB 24
`define MSWT_BORDER_TWO_MSB 23
`define MSWT_BORDER_TWO_LSB 16
`define MSWT_BORDER_ONE_MSB 15
`define MSWT_BORDER_ONE_LSB 8
`define MSWT_SLOPE_THREE_MSB 7
`define MSWT_SLOPE_THREE_LSB 6
`define MSWT_SLOPE_TWO_MSB 5
`define MSWT_SLOPE_TWO_LSB 4
`define MSWT_SLOPE_ONE_MSB 3
`define MSWT_SLOPE_ONE_LSB 2
`define MSWT_SLOPE_ZERO_MSB 1
`define MSWT_SLOPE_ZERO_LSB 0

// start value fields
`define MSWT_START_A_MSB 7
`define MSWT_START_A_LSB 0
`define MSWT_START_B_MSB 23
`define MSWT_START_B_LSB 16
`define MSWT_START_MASK 32'h00ff00ff

// coil value register fields
`define MSWT_COIL_A_LSB 0
`define MSWT_COIL_B_LSB 16

// fixed start positions and quarter size
`define MSWT_PHASE_B_OFFSET 10'h100
`define MSWT_QUARTER_LAST 8'hff

// reset values
`define MSWT_SEG_CFG_RST 32'hffff8056
`define MSWT_START_RST 32'h00f70000
`define MSWT_TABLE_RST 32'h00000000

`endif

// ---- pkg/mswt_pkg.sv ----
package mswt_pkg;

  typedef enum logic [0:0] {
    MSWT_BUS_IDLE,
    MSWT_BUS_DONE
  } mswt_bus_t;

  typedef struct packed {
    logic [7:0][31:0] table_words;
    logic [31:0] seg_cfg;
    logic [31:0] start_vals;
    logic [9:0] position;
    logic [8:0] mag_a;
    logic [8:0] mag_b;
    logic [8:0] coil_a;
    logic [8:0] coil_b;
    mswt_bus_t bus;
    logic [31:0] rdata;
  } mswt_state_t;

endpackage

// ---- hw/mswt_top.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "mswt_map.svh"

module mswt_top
(
  // clock and reset
  input wire logic CLOCK,
  input wire logic SRST,
  // avalon-mm slave, byte addressed
  input wire logic [9:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // microstep advance from the ramp logic
  input wire logic STEP_ADVANCE,
  input wire logic STEP_FORWARD,
  // wave outputs
  output logic [9:0] MICROSTEP_POSITION,
  output logic [8:0] COIL_A_VALUE,
  output logic [8:0] COIL_B_VALUE
);

  ////////////////////////////////////////////////////////////////////////////////
  // increment of one table entry

  function automatic logic signed [3:0] inc_of(input logic [7:0] j, input logic [31:0] cfg,
                                               input logic [7:0][31:0] bits);
    logic [1:0] w;
    logic [255:0] flat;
    flat = bits;
    if (j >= cfg[`MSWT_BORDER_THREE_MSB:`MSWT_BORDER_THREE_LSB])
      w = cfg[`MSWT_SLOPE_THREE_MSB:`MSWT_SLOPE_THREE_LSB];
    else if (j >= cfg[`MSWT_BORDER_TWO_MSB:`MSWT_BORDER_TWO_LSB])
      w = cfg[`MSWT_SLOPE_TWO_MSB:`MSWT_SLOPE_TWO_LSB];
    else if (j >= cfg[`MSWT_BORDER_ONE_MSB:`MSWT_BORDER_ONE_LSB])
      w = cfg[`MSWT_SLOPE_ONE_MSB:`MSWT_SLOPE_ONE_LSB];
    else
      w = cfg[`MSWT_SLOPE_ZERO_MSB:`MSWT_SLOPE_ZERO_LSB];
    // slope plus delta bit minus one: range -1 to 3
    return $signed({2'b00, w}) + $signed({3'b000, flat[j]}) - 4'sh1;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // one microstep of one phase; pos is the phase position before the step

  function automatic logic [8:0] advance(input logic [8:0] mag, input logic [9:0] pos, input logic fwd,
                                         input logic [31:0] cfg, input logic [7:0][31:0] bits);
    logic [9:0] lower;
    logic [7:0] j;
    logic signed [3:0] d;
    logic [8:0] dx;
    // the step spans lower..lower+1 whichever way it goes
    lower = fwd ? pos : pos - 10'h001;
    // even quadrants walk the table forward, odd ones backward
    j = lower[8] ? `MSWT_QUARTER_LAST - lower[7:0] : lower[7:0];
    d = inc_of(j, cfg, bits);
    dx = {{5{d[3]}}, d};
    if (fwd ^ lower[8])
      return mag + dx;
    else
      return mag - dx;
  endfunction

  // magnitude to signed coil value; the upper half wave is negated
  function automatic logic [8:0] to_coil(input logic [8:0] mag, input logic [9:0] pos);
    return pos[9] ? 9'h000 - mag : mag;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // state

  mswt_pkg::mswt_state_t s_q;
  mswt_pkg::mswt_state_t s_d;

  logic request;
  logic [7:0] reg_index;
  logic [31:0] lane_mask;
  logic [31:0] read_mux;
  logic [9:0] pos_b_q;
  logic [9:0] pos_next;
  logic [9:0] pos_b_next;

  assign request = AVS_READ | AVS_WRITE;
  assign reg_index = AVS_ADDRESS[9:2];
  assign pos_b_q = s_q.position + `MSWT_PHASE_B_OFFSET;

  // byte enables widened to a bit mask
  genvar lane;
  generate
    for (lane = 0; lane < 4; lane = lane + 1)
    begin : gen_lane
      assign lane_mask[lane*8 +: 8] = {8{AVS_BYTEENABLE[lane]}};
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // read multiplexer

  always_comb
  begin
    read_mux = 32'h00000000;
    if (reg_index >= `MSWT_IDX_TABLE_FIRST && reg_index <= `MSWT_IDX_TABLE_LAST)
      read_mux = s_q.table_words[reg_index[2:0]];
    else
    begin
      case (reg_index)
        `MSWT_IDX_SEG_CFG: read_mux = s_q.seg_cfg;
        `MSWT_IDX_POSITION: read_mux = {22'h000000, s_q.position};
        `MSWT_IDX_COIL: read_mux = {{7{s_q.coil_b[8]}}, s_q.coil_b, {7{s_q.coil_a[8]}}, s_q.coil_a};
        `MSWT_IDX_START: read_mux = s_q.start_vals;
        default: read_mux = 32'h00000000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    s_d = s_q;
    pos_next = STEP_FORWARD ? s_q.position + 10'h001 : s_q.position - 10'h001;
    pos_b_next = pos_next + `MSWT_PHASE_B_OFFSET;

    // bus: one wait cycle, then the answer
    case (s_q.bus)
      mswt_pkg::MSWT_BUS_IDLE:
      begin
        if (request)
        begin
          s_d.bus = mswt_pkg::MSWT_BUS_DONE;
          s_d.rdata = AVS_READ ? read_mux : 32'h00000000;
        end
      end
      mswt_pkg::MSWT_BUS_DONE:
      begin
        s_d.bus = mswt_pkg::MSWT_BUS_IDLE;
        if (AVS_WRITE)
        begin
          if (reg_index >= `MSWT_IDX_TABLE_FIRST && reg_index <= `MSWT_IDX_TABLE_LAST)
            s_d.table_words[reg_index[2:0]] = (s_q.table_words[reg_index[2:0]] & ~lane_mask)
                                              | (AVS_WRITEDATA & lane_mask);
          else if (reg_index == `MSWT_IDX_SEG_CFG)
            s_d.seg_cfg = (s_q.seg_cfg & ~lane_mask) | (AVS_WRITEDATA & lane_mask);
          else if (reg_index == `MSWT_IDX_START)
            s_d.start_vals = ((s_q.start_vals & ~lane_mask) | (AVS_WRITEDATA & lane_mask))
                             & `MSWT_START_MASK;
        end
      end
      default: s_d.bus = mswt_pkg::MSWT_BUS_IDLE;
    endcase

    // microstep advance
    if (STEP_ADVANCE)
    begin
      s_d.position = pos_next;
      if (pos_next == 10'h000)
      begin
        // absolute realignment at zero
        s_d.mag_a = {1'b0, s_q.start_vals[`MSWT_START_A_MSB:`MSWT_START_A_LSB]};
        s_d.mag_b = {1'b0, s_q.start_vals[`MSWT_START_B_MSB:`MSWT_START_B_LSB]};
      end
      else
      begin
        s_d.mag_a = advance(s_q.mag_a, s_q.position, STEP_FORWARD, s_q.seg_cfg, s_q.table_words);
        s_d.mag_b = advance(s_q.mag_b, pos_b_q, STEP_FORWARD, s_q.seg_cfg, s_q.table_words);
      end
      s_d.coil_a = to_coil(s_d.mag_a, pos_next);
      s_d.coil_b = to_coil(s_d.mag_b, pos_b_next);
    end
  end

  always_ff @(posedge CLOCK)
  begin
    if (SRST)
    begin
      s_q.table_words <= {8{`MSWT_TABLE_RST}};
      s_q.seg_cfg <= `MSWT_SEG_CFG_RST;
      s_q.start_vals <= `MSWT_START_RST;
      s_q.position <= 10'h000;
      s_q.mag_a <= {1'b0, 8'h00};
      s_q.mag_b <= {1'b0, 8'hf7};
      s_q.coil_a <= {1'b0, 8'h00};
      s_q.coil_b <= {1'b0, 8'hf7};
      s_q.bus <= mswt_pkg::MSWT_BUS_IDLE;
      s_q.rdata <= 32'h00000000;
    end
    else
      s_q <= s_d;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs

  assign AVS_WAITREQUEST = request && (s_q.bus != mswt_pkg::MSWT_BUS_DONE);
  assign AVS_READDATA = s_q.rdata;
  assign MICROSTEP_POSITION = s_q.position;
  assign COIL_A_VALUE = s_q.coil_a;
  assign COIL_B_VALUE = s_q.coil_b;

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  logic signed [3:0] inc_a_now;
  logic [8:0] inc_a_ext;
  logic [1:0] slope_at_border_one;
  logic [7:0][31:0] one_hot_bits;

  assign inc_a_now = inc_of(s_q.position[7:0], s_q.seg_cfg, s_q.table_words);
  assign inc_a_ext = {{5{inc_a_now[3]}}, inc_a_now};
  assign one_hot_bits = '0;
  assign slope_at_border_one = 2'(inc_of(s_q.seg_cfg[`MSWT_BORDER_ONE_MSB:`MSWT_BORDER_ONE_LSB],
                                         s_q.seg_cfg, one_hot_bits) + 4'sh1);

  default clocking chk_clk @(posedge CLOCK);
  endclocking
  default disable iff (SRST);

  chk_wait_one: // bus
  assert property ((request && s_q.bus == mswt_pkg::MSWT_BUS_IDLE) |-> AVS_WAITREQUEST ##1 !AVS_WAITREQUEST)
    else $error("answer not given after one wait cycle");

  chk_counter_step:
  assert property (STEP_ADVANCE |=> MICROSTEP_POSITION == ($past(STEP_FORWARD) ?
                   10'($past(MICROSTEP_POSITION) + 10'h001) : 10'($past(MICROSTEP_POSITION) - 10'h001)))
    else $error("microstep position did not move by one");

  chk_zero_reload:
  assert property ((STEP_ADVANCE && pos_next == 10'h000) |=>
                   COIL_A_VALUE == {1'b0, s_q.start_vals[7:0]} && COIL_B_VALUE == {1'b0, s_q.start_vals[23:16]})
    else $error("coils not reloaded at zero");

  chk_coil_hold:
  assert property ((!STEP_ADVANCE) |=> $stable(COIL_A_VALUE) && $stable(COIL_B_VALUE) && $stable(MICROSTEP_POSITION))
    else $error("coil value changed without an advance");

  chk_inc_forward:
  assert property ((STEP_ADVANCE && STEP_FORWARD && s_q.position[9:8] == 2'b00 && s_q.position[7:0] != 8'hff)
                   |=> s_q.mag_a == 9'($past(s_q.mag_a) + $past(inc_a_ext)))
    else $error("forward increment wrong in first quadrant");

  chk_negate_half:
  assert property ((STEP_ADVANCE && pos_next[9]) |=> COIL_A_VALUE == 9'(9'h000 - s_q.mag_a))
    else $error("upper half wave not negated");

  chk_phase_quarter:
  assert property ((STEP_ADVANCE && pos_next == 10'h300) |=> COIL_B_VALUE == s_q.mag_b && !COIL_B_VALUE[8] ||
                   s_q.mag_b[8])
    else $error("phase b not a quarter ahead");

  chk_border_slope:
  assert property ((s_q.seg_cfg[15:8] < s_q.seg_cfg[23:16] && s_q.seg_cfg[15:8] < s_q.seg_cfg[31:24]) |->
                   slope_at_border_one == s_q.seg_cfg[`MSWT_SLOPE_ONE_MSB:`MSWT_SLOPE_ONE_LSB])
    else $error("border index took wrong slope");

  chk_cfg_write:
  assert property ((AVS_WRITE && !AVS_WAITREQUEST && reg_index == `MSWT_IDX_SEG_CFG && AVS_BYTEENABLE == 4'hf)
                   |=> s_q.seg_cfg == $past(AVS_WRITEDATA))
    else $error("segment configuration not written");

  chk_table_write:
  assert property ((AVS_WRITE && !AVS_WAITREQUEST && reg_index == `MSWT_IDX_TABLE_FIRST && AVS_BYTEENABLE == 4'hf)
                   |=> s_q.table_words[0] == $past(AVS_WRITEDATA))
    else $error("table word not written");

  chk_read_coil:
  assert property ((AVS_READ && s_q.bus == mswt_pkg::MSWT_BUS_IDLE && reg_index == `MSWT_IDX_COIL && !STEP_ADVANCE)
                   |=> AVS_READDATA[8:0] == COIL_A_VALUE && AVS_READDATA[24:16] == COIL_B_VALUE)
    else $error("coil register read back wrong");

  ////////////////////////////////////////////////////////////////////////////////
  // bus protocol checks

  chk_wait_idle: // bus
  assert property ((!request) |-> !AVS_WAITREQUEST)
    else $error("waitrequest high without a request");

  chk_done_once: // bus
  assert property ((s_q.bus == mswt_pkg::MSWT_BUS_DONE) |=> s_q.bus == mswt_pkg::MSWT_BUS_IDLE)
    else $error("bus answer lasted more than one cycle");

  chk_rdata_hold: // bus
  assert property ((!(request && s_q.bus == mswt_pkg::MSWT_BUS_IDLE)) |=> $stable(AVS_READDATA))
    else $error("read data changed outside a read");

  chk_cfg_quiet:
  assert property ((!(AVS_WRITE && s_q.bus == mswt_pkg::MSWT_BUS_DONE)) |=>
                   $stable(s_q.seg_cfg) && $stable(s_q.start_vals) && $stable(s_q.table_words))
    else $error("configuration changed without a write");

  ////////////////////////////////////////////////////////////////////////////////
  // register map checks

  chk_unmapped_read:
  assert property ((AVS_READ && s_q.bus == mswt_pkg::MSWT_BUS_IDLE &&
                    (reg_index < `MSWT_IDX_TABLE_FIRST || reg_index > `MSWT_IDX_START ||
                     (reg_index > `MSWT_IDX_COIL && reg_index < `MSWT_IDX_START)))
                   |=> AVS_READDATA == 32'h00000000)
    else $error("unmapped index read nonzero");

  chk_start_mask:
  assert property ((s_q.start_vals & ~`MSWT_START_MASK) == 32'h00000000)
    else $error("start register holds bits outside its fields");

  chk_start_write:
  assert property ((AVS_WRITE && !AVS_WAITREQUEST && reg_index == `MSWT_IDX_START && AVS_BYTEENABLE == 4'hf)
                   |=> s_q.start_vals == ($past(AVS_WRITEDATA) & `MSWT_START_MASK))
    else $error("start register not written");

  chk_cfg_read:
  assert property ((AVS_READ && s_q.bus == mswt_pkg::MSWT_BUS_IDLE && reg_index == `MSWT_IDX_SEG_CFG)
                   |=> AVS_READDATA == s_q.seg_cfg)
    else $error("segment configuration read back wrong");

  chk_start_read:
  assert property ((AVS_READ && s_q.bus == mswt_pkg::MSWT_BUS_IDLE && reg_index == `MSWT_IDX_START)
                   |=> AVS_READDATA == s_q.start_vals)
    else $error("start register read back wrong");

  chk_table_read:
  assert property ((AVS_READ && s_q.bus == mswt_pkg::MSWT_BUS_IDLE && reg_index == `MSWT_IDX_TABLE_FIRST)
                   |=> AVS_READDATA == s_q.table_words[0])
    else $error("first table word read back wrong");

  chk_pos_read:
  assert property ((AVS_READ && s_q.bus == mswt_pkg::MSWT_BUS_IDLE && reg_index == `MSWT_IDX_POSITION &&
                    !STEP_ADVANCE) |=> AVS_READDATA == {22'h000000, MICROSTEP_POSITION})
    else $error("position read back wrong");

  chk_pos_ro:
  assert property ((AVS_WRITE && !AVS_WAITREQUEST && reg_index == `MSWT_IDX_POSITION && !STEP_ADVANCE)
                   |=> $stable(MICROSTEP_POSITION))
    else $error("position changed by a write");

  ////////////////////////////////////////////////////////////////////////////////
  // wave checks

  chk_inc_range:
  assert property (inc_a_now >= -4'sh1 && inc_a_now <= 4'sh3)
    else $error("increment outside minus one to three");

  chk_coil_a_low:
  assert property ((STEP_ADVANCE && !pos_next[9]) |=> COIL_A_VALUE == s_q.mag_a)
    else $error("lower half wave of phase a altered");

  chk_coil_b_half:
  assert property ((STEP_ADVANCE && pos_b_next[9]) |=> COIL_B_VALUE == 9'(9'h000 - s_q.mag_b))
    else $error("upper half wave of phase b not negated");

  chk_coil_b_low:
  assert property ((STEP_ADVANCE && !pos_b_next[9]) |=> COIL_B_VALUE == s_q.mag_b)
    else $error("lower half wave of phase b altered");

endmodule

`default_nettype wire

// ---- tb/mswt_top_bench.sv ----
`timescale 1ns/100ps
`default_nettype none
module mswt_top_bench;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic [9:0] avs_address = 10'h000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic step_advance = 1'b0;
  logic step_forward = 1'b1;
  logic [9:0] microstep_position;
  logic [8:0] coil_a_value;
  logic [8:0] coil_b_value;
  int num_errors = 0;
  int checks_done = 0;
  logic [31:0] tbl [0:7];
  logic [31:0] cfg = 32'hffff8056;
  logic [7:0] sa = 8'h00;
  logic [7:0] sb = 8'hf7;
  logic [9:0] pos = 10'h000;
  logic [8:0] ma = 9'h000;
  logic [8:0] mb = 9'h0f7;
  logic [31:0] rd;

  mswt_top i_mswt_top (.CLOCK(clock), .SRST(srst), .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
    .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata), .AVS_BYTEENABLE(avs_byteenable),
    .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest), .STEP_ADVANCE(step_advance),
    .STEP_FORWARD(step_forward), .MICROSTEP_POSITION(microstep_position), .COIL_A_VALUE(coil_a_value),
    .COIL_B_VALUE(coil_b_value));

  always #5 clock = ~clock;

  ////////////////////////////////////////////////////////////////////////////////
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task finish_test;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // request held until waitrequest is seen low, released after that edge
  task bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd, input logic [3:0] be);
    @(posedge clock);
    avs_address <= {idx, 2'b00};
    avs_read <= ~wr;
    avs_write <= wr;
    avs_writedata <= wd;
    avs_byteenable <= be;
    // waitrequest and read data are taken as they stood just before each rising edge
    do
      @(posedge clock);
    while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task rdchk(input string name, input logic [7:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 32'h00000000, 4'hf);
    check(name, rd, exp);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  function logic [8:0] sgn(input logic [8:0] m, input logic neg);
    return neg ? 9'h000 - m : m;
  endfunction

  // incremental step of one magnitude, quarter mirrored by lower[8]
  function logic [8:0] adv(input logic [8:0] m, input logic [9:0] lower, input logic fwd);
    logic [7:0] j;
    logic [1:0] w;
    logic [8:0] inc;
    j = lower[8] ? 8'hff - lower[7:0] : lower[7:0];
    if (j >= cfg[31:24])
      w = cfg[7:6];
    else if (j >= cfg[23:16])
      w = cfg[5:4];
    else if (j >= cfg[15:8])
      w = cfg[3:2];
    else
      w = cfg[1:0];
    inc = {7'h00, w} + {8'h00, tbl[j[7:5]][j[4:0]]} - 9'h001;
    return (fwd ^ lower[8]) ? m + inc : m - inc;
  endfunction

  function logic [31:0] coil_word();
    logic [8:0] ca;
    logic [8:0] cb;
    logic [9:0] pb;
    pb = pos + 10'h100;
    ca = sgn(ma, pos[9]);
    cb = sgn(mb, pb[9]);
    return {{7{cb[8]}}, cb, {7{ca[8]}}, ca};
  endfunction

  task cmp_out;
    logic [31:0] cw;
    cw = coil_word();
    check("position", {22'h000000, microstep_position}, {22'h000000, pos});
    check("coil_a", {23'h000000, coil_a_value}, {23'h000000, cw[8:0]});
    check("coil_b", {23'h000000, coil_b_value}, {23'h000000, cw[24:16]});
  endtask

  task run_steps(input int n, input logic fwd);
    logic [9:0] lower;
    @(posedge clock);
    step_forward <= fwd;
    step_advance <= 1'b1;
    for (int i = 0; i < n; i++)
    begin
      @(posedge clock);
      if (i == n - 1)
        step_advance <= 1'b0;
      lower = fwd ? pos : pos - 10'h001;
      ma = adv(ma, lower, fwd);
      mb = adv(mb, lower + 10'h100, fwd);
      pos = fwd ? pos + 10'h001 : pos - 10'h001;
      if (pos == 10'h000)
      begin
        ma = {1'b0, sa};
        mb = {1'b0, sb};
      end
      @(negedge clock);
      cmp_out;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task test_reset;
    @(negedge clock);
    cmp_out;
    rdchk("seg_cfg", 8'h78, 32'hffff8056);
    rdchk("start", 8'h7e, 32'h00f70000);
    rdchk("coil_reg", 8'h7a, 32'h00f70000);
    rdchk("table_0", 8'h70, 32'h00000000);
  endtask

  task test_regs;
    for (int k = 0; k < 8; k++)
    begin
      tbl[k] = (32'h9e3779b9 * (k + 1)) ^ 32'h0f0f1234;
      bus(1'b1, 8'h70 + k[7:0], tbl[k], 4'hf);
    end
    for (int k = 0; k < 8; k++)
      rdchk("table_word", 8'h70 + k[7:0], tbl[k]);
    bus(1'b1, 8'h78, 32'h12345678, 4'b0101);
    rdchk("seg_cfg_bytes", 8'h78, 32'hff348078);
    bus(1'b1, 8'h7e, 32'hffffffff, 4'hf);
    rdchk("start_mask", 8'h7e, 32'h00ff00ff);
    bus(1'b1, 8'h7a, 32'h12345678, 4'hf);
    rdchk("coil_ro", 8'h7a, 32'h00f70000);
    bus(1'b1, 8'h40, 32'hffffffff, 4'hf);
    rdchk("unmapped", 8'h40, 32'h00000000);
  endtask

  task test_wave;
    cfg = {8'd200, 8'd120, 8'd40, 2'd0, 2'd1, 2'd2, 2'd3};
    bus(1'b1, 8'h78, cfg, 4'hf);
    rdchk("seg_cfg", 8'h78, cfg);
    sa = 8'h05;
    sb = 8'hc8;
    bus(1'b1, 8'h7e, {8'h00, sb, 8'h00, sa}, 4'hf);
    // full turn forward, through the zero pass and on
    run_steps(1030, 1'b1);
    rdchk("coil_reg", 8'h7a, coil_word());
    // backward across zero, then isolated single steps
    run_steps(40, 1'b0);
    for (int k = 0; k < 3; k++)
      run_steps(1, 1'b1);
    rdchk("coil_reg", 8'h7a, coil_word());
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    for (int k = 0; k < 8; k++)
      tbl[k] = 32'h00000000;
    repeat (3) @(posedge clock);
    srst <= 1'b0;
    test_reset;
    test_regs;
    test_wave;
    finish_test;
  end

  initial
  begin
    repeat (10000) @(posedge clock);
    num_errors++;
    finish_test;
  end
endmodule
`default_nettype wire
